// >>> ecsr_ctrl.sv
// Configuration store/restore controller between register bank and nonvolatile memory
`timescale 1ns/10ps
`default_nettype none
// How it works
// (R01) A 23-byte segment table names register ranges copied to and from memory.
// (R02) Table codes request a commit during restore or mark end of data; both are stored.
// (R03) Default table covers all configuration ranges, then commits.
// (R04) Pending flag reads 1 while a transfer runs, 0 when finished.
// (R05) Pending flag drives the first status pin when its select bit is set.
// (R06) Error flag reads 1 when stored data fails its check.
// (R07) With boot-select low, soft-reload bit resets and restores; it self-clears.
// (R08) Write-enable bit gates memory writes; cleared by default.
// (R09) Store bit starts bank-to-memory copy and self-clears when done.
// (R10) Commit copies buffered to active on next serial clock rise; self-clears.
// (R11) Entries walk in ascending order and stop at the first end code.
// (R12) Software enables writes before storing and polls pending before trusting memory.
module ecsr_ctrl
  import ecsr_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic reg_wr,
  input wire logic [11:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic boot_sel,
  input wire logic sclk_rise,
  output logic bank_rd,
  output logic bank_wr,
  output logic [11:0] bank_addr,
  output logic [7:0] bank_wdata,
  input wire logic [7:0] bank_rdata,
  output logic nv_rd,
  output logic nv_wr,
  output logic [9:0] nv_addr,
  output logic [7:0] nv_wdata,
  input wire logic [7:0] nv_rdata,
  output logic commit_out,
  output logic soft_reset_out,
  output logic status_out_first
);

  ecsr_state_t st_reg, st_next;
  logic mode_reg, mode_next;
  logic [2:0] ph_reg, ph_next;
  logic [4:0] tidx_reg, tidx_next;
  logic [6:0] cnt_reg, cnt_next;
  logic [11:0] addr_reg, addr_next;
  logic [9:0] nvp_reg, nvp_next;
  logic [7:0] csum_reg, csum_next;
  logic pend_reg, pend_next;
  logic err_reg, err_next;
  logic wren_reg, wren_next;
  logic pinsel_reg, pinsel_next;
  logic cpend_reg, cpend_next;
  logic commit_reg, commit_next;
  logic soft_reg, soft_next;
  logic boot_done_reg, boot_done_next;
  logic status_reg, status_next;
  logic [7:0] rdata_reg, rdata_next;
  logic bank_rd_reg, bank_rd_next, bank_wr_reg, bank_wr_next;
  logic [11:0] bank_addr_reg, bank_addr_next;
  logic [7:0] bank_wdata_reg, bank_wdata_next;
  logic nv_rd_reg, nv_rd_next, nv_wr_reg, nv_wr_next;
  logic [9:0] nv_addr_reg, nv_addr_next;
  logic [7:0] nv_wdata_reg, nv_wdata_next;

  logic [7:0] tbl_a, tbl_b, src_byte;
  logic tbl_we, wr_ctl1, wr_ctl2, nv_store_start, reload_start;

  assign tbl_we = reg_wr && ecsr_is_seg(reg_addr) && (st_reg == ST_IDLE);
  assign wr_ctl1 = reg_wr && (reg_addr == ADDR_CTL1);
  assign wr_ctl2 = reg_wr && (reg_addr == ADDR_CTL2);
  // (R07) Reload gated by pin
  assign reload_start = (wr_ctl1 && reg_wdata[SOFT_BIT] && !boot_sel) || (!boot_done_reg && !boot_sel);
  // (R09) Store start decode
  assign nv_store_start = wr_ctl2 && reg_wdata[STORE_BIT] && boot_done_reg && !reload_start;

  ecsr_seg_table u_table (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .wr_en(tbl_we),
    .wr_idx(ecsr_seg_idx(reg_addr)),
    .wr_data(reg_wdata),
    .rd_idx_a(ecsr_seg_idx(reg_addr)),
    .rd_data_a(tbl_a),
    .rd_idx_b(tidx_reg),
    .rd_data_b(tbl_b)
  );

  // Store reads entries from the table and data from the bank; restore reads all from memory
  assign src_byte = !mode_reg ? nv_rdata : ((ph_reg == PH_DATA) ? bank_rdata : tbl_b);

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_next = st_reg;
    mode_next = mode_reg;
    ph_next = ph_reg;
    tidx_next = tidx_reg;
    cnt_next = cnt_reg;
    addr_next = addr_reg;
    nvp_next = nvp_reg;
    csum_next = csum_reg;
    pend_next = pend_reg;
    err_next = err_reg;
    cpend_next = cpend_reg;
    bank_rd_next = 1'b0;
    bank_wr_next = 1'b0;
    bank_addr_next = bank_addr_reg;
    bank_wdata_next = bank_wdata_reg;
    nv_rd_next = 1'b0;
    nv_wr_next = 1'b0;
    nv_addr_next = nv_addr_reg;
    nv_wdata_next = nv_wdata_reg;
    case (st_reg)
      ST_IDLE: begin
        if (reload_start || nv_store_start) begin
          st_next = ST_ISSUE;
          mode_next = nv_store_start;
          ph_next = PH_ENTRY;
          tidx_next = 5'h00;
          nvp_next = 10'h000;
          csum_next = RST_BYTE;
          pend_next = 1'b1;
          // Store with writes locked still walks but is flagged
          err_next = nv_store_start && !wren_reg;
        end
      end
      ST_ISSUE: begin
        st_next = ST_WAIT;
        // (R11) Stop on table overrun
        if ((ph_reg < PH_DATA) && (tidx_reg >= SEG_COUNT)) begin
          st_next = ST_IDLE;
          pend_next = 1'b0;
          err_next = 1'b1;
        end else if (mode_reg && (ph_reg == PH_CSUM)) begin
          // (R08) Write gate
          nv_wr_next = wren_reg;
          nv_addr_next = nvp_reg;
          nv_wdata_next = csum_reg;
          st_next = ST_IDLE;
          pend_next = 1'b0;
        end else if (mode_reg && (ph_reg == PH_DATA)) begin
          bank_rd_next = 1'b1;
          bank_addr_next = addr_reg;
        end else if (!mode_reg) begin
          nv_rd_next = 1'b1;
          nv_addr_next = nvp_reg;
          nvp_next = nvp_reg + 10'h001;
        end
      end
      ST_WAIT: begin
        st_next = ST_TAKE;
      end
      ST_TAKE: begin
        st_next = ST_ISSUE;
        if (ph_reg != PH_CSUM) begin
          csum_next = csum_reg ^ src_byte;
          if (mode_reg) begin
            // (R08) Write gate
            nv_wr_next = wren_reg;
            nv_addr_next = nvp_reg;
            nv_wdata_next = src_byte;
            nvp_next = nvp_reg + 10'h001;
          end
        end
        case (ph_reg)
          PH_ENTRY: begin
            tidx_next = tidx_reg + 5'h01;
            if (!src_byte[OP_FLAG_BIT]) begin
              cnt_next = src_byte[6:0];
              ph_next = PH_ADDR_HI;
            end else if (src_byte == OP_COMMIT) begin
              // (R02) Table-issued commit
              cpend_next = !mode_reg;
            end else begin
              // (R11) End code ends the walk
              ph_next = PH_CSUM;
            end
          end
          PH_ADDR_HI: begin
            tidx_next = tidx_reg + 5'h01;
            addr_next = {src_byte[3:0], addr_reg[7:0]};
            ph_next = PH_ADDR_LO;
          end
          PH_ADDR_LO: begin
            tidx_next = tidx_reg + 5'h01;
            addr_next = {addr_reg[11:8], src_byte};
            ph_next = PH_DATA;
          end
          PH_DATA: begin
            // (R01) Range copy
            bank_wr_next = !mode_reg;
            bank_addr_next = addr_reg;
            bank_wdata_next = src_byte;
            addr_next = addr_reg + 12'h001;
            if (cnt_reg == 7'h00) begin
              ph_next = PH_ENTRY;
            end else begin
              cnt_next = cnt_reg - 7'h01;
            end
          end
          default: begin
            // (R06) Stored check byte
            err_next = (src_byte != csum_reg);
            st_next = ST_IDLE;
            pend_next = 1'b0;
          end
        endcase
      end
      default: begin
        st_next = ST_IDLE;
        pend_next = 1'b0;
      end
    endcase
    // (R10) Software commit; a new request wins over the firing edge
    if (reg_wr && (reg_addr == ADDR_UPDATE) && reg_wdata[UPDATE_BIT]) begin
      cpend_next = 1'b1;
    end else if (cpend_reg && sclk_rise && (cpend_next == cpend_reg)) begin
      cpend_next = 1'b0;
    end
    if (!rst_n) begin
      st_next = ST_IDLE;
      pend_next = RST_FLAG;
      err_next = RST_FLAG;
      cpend_next = RST_FLAG;
      bank_rd_next = RST_FLAG;
      bank_wr_next = RST_FLAG;
      nv_rd_next = RST_FLAG;
      nv_wr_next = RST_FLAG;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    wren_next = wr_ctl1 ? reg_wdata[WREN_BIT] : wren_reg;
    pinsel_next = (reg_wr && (reg_addr == ADDR_PINSEL)) ? reg_wdata[PINSEL_BIT] : pinsel_reg;
    // (R10) Fire on serial clock rise
    commit_next = cpend_reg && sclk_rise;
    // (R07) One-cycle reset pulse
    soft_next = wr_ctl1 && reg_wdata[SOFT_BIT] && !boot_sel;
    boot_done_next = 1'b1;
    // (R05) Status pin routing
    status_next = pend_next && pinsel_next;
    rdata_next = RST_BYTE;
    if (ecsr_is_seg(reg_addr)) begin
      rdata_next = tbl_a;
    end else begin
      case (reg_addr)
        // (R04) Pending readback
        ADDR_PEND: rdata_next[PEND_BIT] = pend_reg;
        ADDR_ERR: rdata_next[ERR_BIT] = err_reg;
        ADDR_CTL1: begin
          rdata_next[WREN_BIT] = wren_reg;
          rdata_next[SOFT_BIT] = soft_reg;
        end
        ADDR_CTL2: rdata_next[STORE_BIT] = pend_reg && mode_reg;
        ADDR_PINSEL: rdata_next[PINSEL_BIT] = pinsel_reg;
        ADDR_UPDATE: rdata_next[UPDATE_BIT] = cpend_reg;
        default: rdata_next = RST_BYTE;
      endcase
    end
    if (!rst_n) begin
      wren_next = RST_FLAG;
      pinsel_next = RST_FLAG;
      commit_next = RST_FLAG;
      soft_next = RST_FLAG;
      boot_done_next = RST_FLAG;
      status_next = RST_FLAG;
      rdata_next = RST_BYTE;
    end
  end

  always_ff @(posedge clk_sys) begin
    st_reg <= st_next;
    mode_reg <= mode_next;
    ph_reg <= ph_next;
    tidx_reg <= tidx_next;
    cnt_reg <= cnt_next;
    addr_reg <= addr_next;
    nvp_reg <= nvp_next;
    csum_reg <= csum_next;
    pend_reg <= pend_next;
    err_reg <= err_next;
    wren_reg <= wren_next;
    pinsel_reg <= pinsel_next;
    cpend_reg <= cpend_next;
    commit_reg <= commit_next;
    soft_reg <= soft_next;
    boot_done_reg <= boot_done_next;
    status_reg <= status_next;
    rdata_reg <= rdata_next;
    bank_rd_reg <= bank_rd_next;
    bank_wr_reg <= bank_wr_next;
    bank_addr_reg <= bank_addr_next;
    bank_wdata_reg <= bank_wdata_next;
    nv_rd_reg <= nv_rd_next;
    nv_wr_reg <= nv_wr_next;
    nv_addr_reg <= nv_addr_next;
    nv_wdata_reg <= nv_wdata_next;
  end

  assign reg_rdata = rdata_reg;
  assign bank_rd = bank_rd_reg;
  assign bank_wr = bank_wr_reg;
  assign bank_addr = bank_addr_reg;
  assign bank_wdata = bank_wdata_reg;
  assign nv_rd = nv_rd_reg;
  assign nv_wr = nv_wr_reg;
  assign nv_addr = nv_addr_reg;
  assign nv_wdata = nv_wdata_reg;
  assign commit_out = commit_reg;
  assign soft_reset_out = soft_reg;
  assign status_out_first = status_reg;

  ////////////////////////////////////////////////////////////////////////////
  sequence s_take_entry;
    (st_reg == ST_TAKE) && (ph_reg == PH_ENTRY);
  endsequence

  sequence s_store_go;
    nv_store_start && (st_reg == ST_IDLE);
  endsequence

  property p_pend_busy;
    @(posedge clk_sys) disable iff (!rst_n) pend_reg == (st_reg != ST_IDLE);
  endproperty
  a_pend_busy: assert property (p_pend_busy) else $error("pending flag disagrees with walk state"); // R04

  property p_status_pin;
    @(posedge clk_sys) disable iff (!rst_n) status_out_first == (pend_reg && pinsel_reg);
  endproperty
  a_status_pin: assert property (p_status_pin) else $error("status pin not routed"); // R05

  property p_store_go;
    @(posedge clk_sys) disable iff (!rst_n) s_store_go |=> pend_reg && mode_reg ##1 (st_reg == ST_WAIT);
  endproperty
  a_store_go: assert property (p_store_go) else $error("store did not start"); // R09

  property p_wr_gate;
    @(posedge clk_sys) disable iff (!rst_n) nv_wr |-> $past(wren_reg);
  endproperty
  a_wr_gate: assert property (p_wr_gate) else $error("memory written while locked"); // R08

  property p_soft;
    @(posedge clk_sys) disable iff (!rst_n)
      (wr_ctl1 && reg_wdata[SOFT_BIT] && !boot_sel && boot_done_reg && (st_reg == ST_IDLE))
      |=> soft_reset_out && pend_reg && !mode_reg;
  endproperty
  a_soft: assert property (p_soft) else $error("soft reload missing"); // R07

  property p_commit;
    @(posedge clk_sys) disable iff (!rst_n) (cpend_reg && sclk_rise) |=> commit_out;
  endproperty
  a_commit: assert property (p_commit) else $error("commit not fired on serial clock rise"); // R10

  property p_tbl_commit;
    @(posedge clk_sys) disable iff (!rst_n) s_take_entry ##0 (!mode_reg && src_byte == OP_COMMIT) |=> cpend_reg;
  endproperty
  a_tbl_commit: assert property (p_tbl_commit) else $error("table commit ignored"); // R02

  property p_end_stop;
    @(posedge clk_sys) disable iff (!rst_n) s_take_entry ##0 (src_byte == OP_END) |=> (ph_reg == PH_CSUM) ##[1:4] !pend_reg;
  endproperty
  a_end_stop: assert property (p_end_stop) else $error("walk ran past end code"); // R11

  property p_overrun;
    @(posedge clk_sys) disable iff (!rst_n)
      ((st_reg == ST_ISSUE) && (ph_reg < PH_DATA) && (tidx_reg >= SEG_COUNT)) |=> err_reg && !pend_reg;
  endproperty
  a_overrun: assert property (p_overrun) else $error("table overrun not stopped"); // R01

  property p_csum_err;
    @(posedge clk_sys) disable iff (!rst_n)
      ((st_reg == ST_TAKE) && (ph_reg == PH_CSUM) && !mode_reg && (nv_rdata != csum_reg)) |=> err_reg;
  endproperty
  a_csum_err: assert property (p_csum_err) else $error("bad data not flagged"); // R06

endmodule // ecsr_ctrl
`default_nettype wire

// >>> ecsr_pkg.sv
// Constants, codes and types shared by the configuration store/restore controller
`default_nettype none
package ecsr_pkg;

  localparam int unsigned REG_AW = 12;
  localparam int unsigned NV_AW = 10;

  // Register map
  localparam logic [11:0] SEG_BASE = 12'hA00;
  localparam logic [11:0] SEG_LAST = 12'hA16;
  localparam logic [4:0] SEG_COUNT = 5'h17;
  localparam logic [11:0] ADDR_PEND = 12'hB00;
  localparam logic [11:0] ADDR_ERR = 12'hB01;
  localparam logic [11:0] ADDR_CTL1 = 12'hB02;
  localparam logic [11:0] ADDR_CTL2 = 12'hB03;
  localparam logic [11:0] ADDR_PINSEL = 12'h232;
  localparam logic [11:0] ADDR_UPDATE = 12'h234;

  // Field positions
  localparam int unsigned PEND_BIT = 0;
  localparam int unsigned ERR_BIT = 0;
  localparam int unsigned WREN_BIT = 0;
  localparam int unsigned SOFT_BIT = 1;
  localparam int unsigned STORE_BIT = 0;
  localparam int unsigned PINSEL_BIT = 4;
  localparam int unsigned UPDATE_BIT = 0;

  // Reset values
  localparam logic RST_FLAG = 1'b0;
  localparam logic [7:0] RST_BYTE = 8'h00;

  // Segment entry codes; bit 7 clear means a range entry whose byte is length-1
  localparam int unsigned OP_FLAG_BIT = 7;
  localparam logic [7:0] OP_COMMIT = 8'h80;
  localparam logic [7:0] OP_END = 8'hFF;

  // Walk phases inside one entry, then the closing check byte
  localparam logic [2:0] PH_ENTRY = 3'h0;
  localparam logic [2:0] PH_ADDR_HI = 3'h1;
  localparam logic [2:0] PH_ADDR_LO = 3'h2;
  localparam logic [2:0] PH_DATA = 3'h3;
  localparam logic [2:0] PH_CSUM = 3'h4;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_ISSUE = 4'h2,
    ST_WAIT = 4'h4,
    ST_TAKE = 4'h8
  } ecsr_state_t;

  // Default table: every configuration range, then a commit, then end of data
  function automatic logic [7:0] ecsr_seg_default(input logic [4:0] idx);
    logic [7:0] v;
    v = OP_END;
    case (idx)
      5'h00: v = 8'h0F;
      5'h01: v = 8'h00;
      5'h02: v = 8'h10;
      5'h03: v = 8'h1F;
      5'h04: v = 8'h00;
      5'h05: v = 8'hF0;
      5'h06: v = 8'h1F;
      5'h07: v = 8'h01;
      5'h08: v = 8'h90;
      5'h09: v = 8'h04;
      5'h0A: v = 8'h02;
      5'h0B: v = 8'h30;
      5'h0C: v = OP_COMMIT;
      default: v = OP_END;
    endcase
    return v;
  endfunction

  function automatic logic ecsr_is_seg(input logic [11:0] a);
    return (a >= SEG_BASE) && (a <= SEG_LAST);
  endfunction

  function automatic logic [4:0] ecsr_seg_idx(input logic [11:0] a);
    logic [11:0] d;
    d = a - SEG_BASE;
    return d[4:0];
  endfunction

endpackage
`default_nettype wire

// >>> ecsr_seg_table.sv
// Segment table storage with default contents and two read ports
`timescale 1ns/10ps
`default_nettype none
module ecsr_seg_table
  import ecsr_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic [4:0] wr_idx,
  input wire logic [7:0] wr_data,
  input wire logic [4:0] rd_idx_a,
  output logic [7:0] rd_data_a,
  input wire logic [4:0] rd_idx_b,
  output logic [7:0] rd_data_b
);

  logic [7:0] mem_reg [0:22];
  logic [7:0] mem_next [0:22];

  // (R03) Default contents
  always_comb begin
    for (int i = 0; i < 23; i++) begin
      if (!rst_n) begin
        mem_next[i] = ecsr_seg_default(5'(i));
      end else if (wr_en && (wr_idx == 5'(i))) begin
        mem_next[i] = wr_data;
      end else begin
        mem_next[i] = mem_reg[i];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    mem_reg <= mem_next;
  end

  // Out-of-range indices read as end of data
  assign rd_data_a = (rd_idx_a < SEG_COUNT) ? mem_reg[rd_idx_a] : OP_END;
  assign rd_data_b = (rd_idx_b < SEG_COUNT) ? mem_reg[rd_idx_b] : OP_END;

endmodule // ecsr_seg_table
`default_nettype wire

// >>> ecsr_nv_mem_model.sv
// Behavioural nonvolatile memory on the far side of the controller's memory port
`timescale 1ns/10ps
`default_nettype none
module ecsr_nv_mem_model (
  input wire logic clk_sys,
  input wire logic nv_rd,
  input wire logic nv_wr,
  input wire logic [9:0] nv_addr,
  input wire logic [7:0] nv_wdata,
  input wire logic flip_en,
  input wire logic [9:0] flip_addr,
  output logic [7:0] nv_rdata
);
  logic [7:0] mem [1024];
  logic [7:0] rd_q;
  logic rd_v;

  // Erased cells read all ones
  initial begin
    for (int i = 0; i < 1024; i++) mem[i] = 8'hFF;
    rd_q = 8'h00;
    rd_v = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // One-cycle read latency; a single bit flip only when the bench asks for it
  always @(posedge clk_sys) begin
    rd_v <= nv_rd;
    if (nv_rd) rd_q <= mem[nv_addr] ^ ((flip_en && nv_addr == flip_addr) ? 8'h01 : 8'h00);
    if (nv_wr) mem[nv_addr] <= nv_wdata;
  end

  // Outside the valid cycle the bus shows inverted data, so a late sample is caught
  assign nv_rdata = rd_v ? rd_q : ~rd_q;
endmodule // ecsr_nv_mem_model
`default_nettype wire

// >>> eeprom_config_store_restore_test.sv
// Self-checking bench for the configuration store/restore controller
`timescale 1ns/10ps
`default_nettype none
module eeprom_config_store_restore_test;
  import ecsr_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic reg_wr = 1'b0;
  logic [11:0] reg_addr = 12'h000;
  logic [7:0] reg_wdata = 8'h00;
  logic boot_sel = 1'b1;
  logic sclk_rise = 1'b0;
  logic flip_en = 1'b0;
  logic [7:0] key = 8'h00;
  logic [7:0] reg_rdata, bank_wdata, bank_rdata, nv_wdata, nv_rdata, d;
  logic [11:0] bank_addr;
  logic [9:0] nv_addr;
  logic bank_rd, bank_wr, nv_rd, nv_wr, commit_out, soft_reset_out, status_out_first, bank_rd_q;
  logic [7:0] tbl [23] = '{8'h0F, 8'h00, 8'h10, 8'h1F, 8'h00, 8'hF0, 8'h1F, 8'h01, 8'h90, 8'h04, 8'h02, 8'h30,
    8'h80, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
  logic [7:0] exp_s[$];
  logic [19:0] exp_b[$];
  logic [19:0] bank_log[$];
  int fail_count = 0;
  int comparisons = 0;
  int commit_n = 0;
  int soft_n = 0;
  int nvwr_n = 0;

  ecsr_ctrl i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .boot_sel(boot_sel), .sclk_rise(sclk_rise),
    .bank_rd(bank_rd), .bank_wr(bank_wr), .bank_addr(bank_addr), .bank_wdata(bank_wdata),
    .bank_rdata(bank_rdata), .nv_rd(nv_rd), .nv_wr(nv_wr), .nv_addr(nv_addr), .nv_wdata(nv_wdata),
    .nv_rdata(nv_rdata), .commit_out(commit_out), .soft_reset_out(soft_reset_out),
    .status_out_first(status_out_first));
  ecsr_nv_mem_model i_mem (.clk_sys(clk_sys), .nv_rd(nv_rd), .nv_wr(nv_wr), .nv_addr(nv_addr),
    .nv_wdata(nv_wdata), .flip_en(flip_en), .flip_addr(10'h005), .nv_rdata(nv_rdata));

  initial begin
    forever #2.5 clk_sys = ~clk_sys;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Buffered bank model: data keyed by address, inverted when not being read
  function automatic logic [7:0] pat(input logic [11:0] a);
    return key ^ a[7:0] ^ {4'h0, a[11:8]};
  endfunction
  assign bank_rdata = bank_rd_q ? pat(bank_addr) : ~pat(bank_addr);
  always @(posedge clk_sys) begin
    bank_rd_q <= bank_rd;
    if (bank_wr === 1'b1) bank_log.push_back({bank_addr, bank_wdata});
    if (commit_out === 1'b1) commit_n++;
    if (soft_reset_out === 1'b1) soft_n++;
    if (nv_wr === 1'b1) nvwr_n++;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Reference walk: expected memory stream and expected bank writes
  function automatic void build();
    int i;
    logic [11:0] a;
    logic [7:0] cs;
    exp_s.delete();
    exp_b.delete();
    cs = 8'h00;
    i = 0;
    while (i < 21) begin
      exp_s.push_back(tbl[i]);
      if (tbl[i] < 8'h80) begin
        a = {tbl[i + 1][3:0], tbl[i + 2]};
        exp_s.push_back(tbl[i + 1]);
        exp_s.push_back(tbl[i + 2]);
        for (int k = 0; k <= int'(tbl[i]); k++) begin
          exp_s.push_back(pat(a));
          exp_b.push_back({a, pat(a)});
          a = a + 12'h001;
        end
        i += 3;
      end else if (tbl[i] == OP_COMMIT) i++;
      else break;
    end
    foreach (exp_s[k]) cs ^= exp_s[k];
    exp_s.push_back(cs);
  endfunction

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] expd);
    comparisons++;
    if (seen !== expd) begin
      fail_count++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, expd, seen);
    end
  endtask

  task automatic test_done();
    $display("Comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    @(negedge clk_sys);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = v;
    @(negedge clk_sys);
    reg_wr = 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, output logic [7:0] v);
    @(negedge clk_sys);
    reg_addr = a;
    @(negedge clk_sys);
    v = reg_rdata;
  endtask

  task automatic wait_idle();
    logic [7:0] v;
    int n;
    n = 0;
    v = 8'h01;
    while (v[PEND_BIT] !== 1'b0) begin
      rd(ADDR_PEND, v);
      n++;
      if (n > 3000) begin
        check("pending_wait", 32'h1, 32'h0);
        test_done();
      end
    end
  endtask

  task automatic sclk_pulse();
    @(negedge clk_sys);
    sclk_rise = 1'b1;
    @(negedge clk_sys);
    sclk_rise = 1'b0;
    repeat (2) @(negedge clk_sys);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    static logic [11:0] regs [6] = '{ADDR_PEND, ADDR_ERR, ADDR_CTL1, ADDR_CTL2, ADDR_PINSEL, 12'h7FF};
    logic [7:0] r;
    int c0;
    void'($urandom(32'h4563));
    key = 8'($urandom());
    repeat (5) @(negedge clk_sys);
    rst_n = 1'b1;
    foreach (regs[k]) begin
      rd(regs[k], d);
      check("reset_value", d, 8'h00);
    end
    for (int k = 0; k < 23; k++) begin
      rd(SEG_BASE + 12'(k), d);
      check("table_default", d, tbl[k]);
    end
    r = 8'($urandom());
    wr(SEG_LAST, r);
    rd(SEG_LAST, d);
    check("table_write", d, r);
    tbl[22] = r;
    build();
    // Store with writes still locked
    wr(ADDR_CTL2, 8'h01);
    wait_idle();
    check("locked_nv_writes", nvwr_n, 0);
    rd(ADDR_ERR, d);
    check("locked_error", d, 8'h01);
    // unlock before storing, then poll pending
    wr(ADDR_CTL1, 8'h01);
    wr(ADDR_PINSEL, 8'h10);
    wr(ADDR_CTL2, 8'h01);
    check("status_pin", status_out_first, 1'b1);
    rd(ADDR_CTL2, d);
    check("store_busy", d, 8'h01);
    wait_idle();
    check("status_pin_idle", status_out_first, 1'b0);
    rd(ADDR_CTL2, d);
    check("store_clear", d, 8'h00);
    rd(ADDR_ERR, d);
    check("store_error", d, 8'h00);
    check("nv_write_count", nvwr_n, exp_s.size());
    foreach (exp_s[k]) check("nv_byte", i_mem.mem[k], exp_s[k]);
    // Reload refused while boot-select is high
    c0 = soft_n;
    wr(ADDR_CTL1, 8'h03);
    repeat (4) @(negedge clk_sys);
    check("reload_refused", soft_n, c0);
    boot_sel = 1'b0;
    bank_log.delete();
    c0 = commit_n;
    wr(ADDR_CTL1, 8'h02);
    repeat (2) @(negedge clk_sys);
    wait_idle();
    check("soft_reset", soft_n, 1);
    rd(ADDR_CTL1, d);
    check("reload_clear", d[SOFT_BIT], 1'b0);
    rd(ADDR_ERR, d);
    check("restore_error", d, 8'h00);
    check("bank_write_count", bank_log.size(), exp_b.size());
    foreach (exp_b[k]) check("bank_write", (k < bank_log.size()) ? bank_log[k] : 20'h0, exp_b[k]);
    check("commit_before_sclk", commit_n, c0);
    sclk_pulse();
    check("table_commit", commit_n, c0 + 1);
    // Corrupted memory byte must be flagged on restore
    flip_en = 1'b1;
    wr(ADDR_CTL1, 8'h02);
    repeat (2) @(negedge clk_sys);
    wait_idle();
    rd(ADDR_ERR, d);
    check("corrupt_error", d, 8'h01);
    flip_en = 1'b0;
    sclk_pulse();
    // Software commit waits for the serial clock edge
    c0 = commit_n;
    wr(ADDR_UPDATE, 8'h01);
    repeat (3) @(negedge clk_sys);
    check("commit_held", commit_n, c0);
    sclk_pulse();
    check("commit_fired", commit_n, c0 + 1);
    rd(ADDR_UPDATE, d);
    check("commit_clear", d, 8'h00);
    // Reset while idle with boot-select low restores on its own
    bank_log.delete();
    rst_n = 1'b0;
    repeat (5) @(negedge clk_sys);
    rst_n = 1'b1;
    rd(ADDR_PEND, d);
    check("auto_restore_busy", d, 8'h01);
    wait_idle();
    check("auto_restore_count", bank_log.size(), exp_b.size());
    rd(ADDR_ERR, d);
    check("auto_restore_error", d, 8'h00);
    rd(ADDR_UPDATE, d);
    check("auto_restore_commit", d, 8'h01);
    // A table with no end code runs off its last entry and is flagged
    wr(ADDR_CTL1, 8'h01);
    for (int k = 0; k < 23; k++) wr(SEG_BASE + 12'(k), 8'h00);
    wr(ADDR_CTL2, 8'h01);
    wait_idle();
    rd(ADDR_ERR, d);
    check("table_overrun", d, 8'h01);
    test_done();
  end
endmodule // eeprom_config_store_restore_test
`default_nettype wire
